// ### design/ucf_baud_div.sv
// Baud tick divider: one-cycle enable every divisor clocks.
// Assumes divisor changes only while the line is idle.
`timescale 1ns/1ps
module ucf_baud_div (
   // Clock and resets
   input wire logic pclk,
   input wire logic presetn,
   input wire logic hw_reset,
   // Divisor and tick
   input wire logic [15:0] divisor,
   output logic tick
);
   typedef struct packed {
      logic [15:0] cnt;
      logic tick;
   } ucf_div_state_t;

   ucf_div_state_t s_reg, s_next;

   always_comb begin
      s_next = s_reg;
      s_next.tick = 1'b0;
      // A zero divisor behaves as one rather than stalling the line
      if (hw_reset) begin
         s_next.cnt = 16'h0000;
      end else if (s_reg.cnt + 16'h0001 >= divisor) begin
         s_next.cnt = 16'h0000;
         s_next.tick = 1'b1;
      end else begin
         s_next.cnt = s_reg.cnt + 16'h0001;
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         s_reg <= '0;
      end else begin
         s_reg <= s_next;
      end
   end

   assign tick = s_reg.tick;
endmodule // ucf_baud_div

// ### design/ucf_top.sv
// One serial channel: register file on APB, clear-to-send gated transmitter,
// flow-character registers and the channel reset state.
// Assumes presetn is the power-up reset and hw_reset the synchronous reset pin.
//
// Notes on behaviour
// - Clear-to-send gating is off while auto_cts_enable is 0, its reset value.
// - With auto_cts_enable set, no new character starts while clear-to-send is high.
// - With auto_cts_enable set, a queued character starts once clear-to-send is low.
// - A character already being shifted is always finished before sending stops.
// - Four 8-bit read/write registers hold two flow-on and two flow-off characters.
// - Power-up loads divisor high with 0x00 and divisor low with 0x01.
// - The reset pin leaves both divisor bytes unchanged.
// - Reset clears fraction, irq enable, queue, line, modem control, features, flow chars.
// - After reset the interrupt source reads 0x01, nothing pending.
// - After reset the line status reads 0x60, holding register and shifter empty.
// - After reset the scratch pad holds 0xff.
// - Reset does not define the receive and transmit holding contents.
// - Reset clears modem change bits 3-0 and shows inverted modem inputs in 7-4.
// - After reset the interrupt pin floats with select low or in 68 mode, and drives with select high outside 68 mode.
// - Fraction and enhanced control bits change only while the enhance bit is 1.
//
// Chosen here: the APB register port and the address map.
`timescale 1ns/1ps
module ucf_top (
   // Clock and resets
   input wire logic pclk,
   input wire logic presetn,
   input wire logic hw_reset,
   // APB slave
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [7:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   // Modem inputs, active low
   input wire logic cts_n,
   input wire logic dsr_n,
   input wire logic ri_n,
   input wire logic cd_n,
   // Serial and modem outputs
   output logic tx_out,
   output logic rts_n,
   output logic dtr_n,
   output logic receive_ready_n,
   output logic transmit_ready_n,
   // Interrupt pin
   input wire logic irq_output_select,
   input wire logic bus_mode_68,
   output logic irq_out,
   output logic irq_oe,
   output logic irq_level
);
   typedef struct packed {
      logic [7:0] div_lo;
      logic [7:0] div_hi;
      logic [7:0] div_frac;
      logic [7:0] irq_enable;
      logic [7:0] queue_control;
      logic [7:0] line_control;
      logic [7:0] modem_control;
      logic [7:0] scratch_pad;
      logic [7:0] enhanced_features;
      logic [7:0] flow_on_char_first;
      logic [7:0] flow_on_char_second;
      logic [7:0] flow_off_char_first;
      logic [7:0] flow_off_char_second;
      logic [7:0] tx_holding;
      logic thr_full;
      logic [3:0] modem_q;
      logic [3:0] msr_delta;
      logic primed;
      logic [2:0] evt;
      logic [2:0] evt_mask;
      logic [31:0] prdata;
   } ucf_state_t;

   ucf_state_t s_reg, s_next;
   logic tick;
   logic tx_busy;
   logic tx_done;
   logic tx_load;
   logic tx_line;
   logic cts_ok;
   logic wr_acc;
   logic rd_acc;
   logic rd_setup;
   logic enh;
   logic [7:0] isr_val;
   logic [7:0] lsr_val;
   logic [7:0] msr_val;
   logic [3:0] modem_now;
   logic [3:0] modem_chg;
   logic irq_pending;

   function automatic logic [7:0] keep_enh(input logic [7:0] old_v, input logic [7:0] new_v,
                                           input logic [7:0] enh_bits, input logic en);
      keep_enh = en ? new_v : ((old_v & enh_bits) | (new_v & ~enh_bits));
   endfunction

   // ----------------------------------------------------------------
   // Transmit path
   // ----------------------------------------------------------------
   ucf_baud_div u_div (
      .pclk(pclk),
      .presetn(presetn),
      .hw_reset(hw_reset),
      .divisor({s_reg.div_hi, s_reg.div_lo}),
      .tick(tick)
   );

   ucf_tx_shift u_shift (
      .pclk(pclk),
      .presetn(presetn),
      .hw_reset(hw_reset),
      .tick(tick),
      .load(tx_load),
      .data(s_reg.tx_holding),
      .tx(tx_line),
      .busy(tx_busy),
      .done(tx_done)
   );

   // Gating only blocks the start of a character, so a shifting one runs out
   assign cts_ok = !s_reg.enhanced_features[ucf_pkg::EFR_AUTO_CTS] || !s_reg.modem_q[0];
   assign tx_load = s_reg.thr_full && !tx_busy && cts_ok && !hw_reset;

   // ----------------------------------------------------------------
   // Status views
   // ----------------------------------------------------------------
   assign modem_now = {cd_n, ri_n, dsr_n, cts_n};
   // The first edge after power-up only loads the input copy, so no false change
   assign modem_chg = s_reg.primed ? (modem_now ^ s_reg.modem_q) : 4'h0;
   assign msr_val = {~s_reg.modem_q, s_reg.msr_delta};
   assign lsr_val = {1'b0, !s_reg.thr_full && !tx_busy, !s_reg.thr_full, 5'h00};
   assign enh = s_reg.enhanced_features[ucf_pkg::EFR_ENH_ENABLE];

   always_comb begin
      if (s_reg.irq_enable[ucf_pkg::IER_MODEM] && (s_reg.msr_delta != 4'h0)) begin
         isr_val = ucf_pkg::ISR_MODEM;
      end else if (s_reg.irq_enable[ucf_pkg::IER_THR_EMPTY] && !s_reg.thr_full) begin
         isr_val = ucf_pkg::ISR_THR_EMPTY;
      end else begin
         isr_val = ucf_pkg::ISR_NONE;
      end
   end

   // ----------------------------------------------------------------
   // APB decode
   // ----------------------------------------------------------------
   assign pready = 1'b1;
   assign wr_acc = psel && penable && pwrite;
   assign rd_acc = psel && penable && !pwrite;
   assign rd_setup = psel && !penable && !pwrite;

   always_comb begin
      s_next = s_reg;
      s_next.modem_q = modem_now;
      s_next.primed = 1'b1;
      s_next.msr_delta = s_reg.msr_delta | modem_chg;
      if (tx_load) begin
         s_next.thr_full = 1'b0;
      end
      // Clear-on-read drops only what the setup cycle reported, and runs first,
      // so an event after the setup edge or on the access edge survives
      if (rd_acc && paddr == ucf_pkg::ADDR_EVENT_STATUS) begin
         s_next.evt = s_reg.evt & ~s_reg.prdata[2:0];
      end
      if (rd_acc && paddr == ucf_pkg::ADDR_MODEM_STATUS) begin
         s_next.msr_delta = (s_reg.msr_delta & ~s_reg.prdata[3:0]) | modem_chg;
      end
      if (tx_load) begin
         s_next.evt[ucf_pkg::EVT_THR_EMPTY] = 1'b1;
      end
      if (modem_chg[0]) begin
         s_next.evt[ucf_pkg::EVT_CTS_CHANGE] = 1'b1;
      end
      if (tx_done) begin
         s_next.evt[ucf_pkg::EVT_CHAR_DONE] = 1'b1;
      end
      if (wr_acc) begin
         case (paddr)
            ucf_pkg::ADDR_HOLDING: begin
               s_next.tx_holding = pwdata[7:0];
               s_next.thr_full = 1'b1;
            end
            ucf_pkg::ADDR_IRQ_ENABLE: begin
               s_next.irq_enable = keep_enh(s_reg.irq_enable, pwdata[7:0], 8'hf0, enh);
            end
            ucf_pkg::ADDR_IRQ_SOURCE: begin
               s_next.queue_control = keep_enh(s_reg.queue_control, pwdata[7:0], 8'h30, enh);
               if (pwdata[ucf_pkg::FCR_TX_CLEAR]) begin
                  s_next.thr_full = 1'b0;
               end
            end
            ucf_pkg::ADDR_LINE_CONTROL: begin
               s_next.line_control = pwdata[7:0];
            end
            ucf_pkg::ADDR_MODEM_CONTROL: begin
               s_next.modem_control = keep_enh(s_reg.modem_control, pwdata[7:0], 8'he0, enh);
            end
            ucf_pkg::ADDR_SCRATCH_PAD: begin
               s_next.scratch_pad = pwdata[7:0];
            end
            ucf_pkg::ADDR_DIV_LOW: begin
               s_next.div_lo = pwdata[7:0];
            end
            ucf_pkg::ADDR_DIV_HIGH: begin
               s_next.div_hi = pwdata[7:0];
            end
            ucf_pkg::ADDR_DIV_FRACTION: begin
               if (enh) begin
                  s_next.div_frac = pwdata[7:0];
               end
            end
            ucf_pkg::ADDR_ENH_FEATURES: begin
               s_next.enhanced_features = pwdata[7:0];
            end
            ucf_pkg::ADDR_FLOW_ON_FIRST: begin
               s_next.flow_on_char_first = pwdata[7:0];
            end
            ucf_pkg::ADDR_FLOW_ON_SECOND: begin
               s_next.flow_on_char_second = pwdata[7:0];
            end
            ucf_pkg::ADDR_FLOW_OFF_FIRST: begin
               s_next.flow_off_char_first = pwdata[7:0];
            end
            ucf_pkg::ADDR_FLOW_OFF_SECOND: begin
               s_next.flow_off_char_second = pwdata[7:0];
            end
            ucf_pkg::ADDR_EVENT_MASK: begin
               s_next.evt_mask = pwdata[2:0];
            end
            default: begin
            end
         endcase
      end
      // Read data is captured in the setup cycle and held through the access
      if (rd_setup) begin
         case (paddr)
            ucf_pkg::ADDR_HOLDING: s_next.prdata = {24'h0, ucf_pkg::RX_HOLDING_IDLE};
            ucf_pkg::ADDR_IRQ_ENABLE: s_next.prdata = {24'h0, s_reg.irq_enable};
            ucf_pkg::ADDR_IRQ_SOURCE: s_next.prdata = {24'h0, isr_val};
            ucf_pkg::ADDR_LINE_CONTROL: s_next.prdata = {24'h0, s_reg.line_control};
            ucf_pkg::ADDR_MODEM_CONTROL: s_next.prdata = {24'h0, s_reg.modem_control};
            ucf_pkg::ADDR_LINE_STATUS: s_next.prdata = {24'h0, lsr_val};
            ucf_pkg::ADDR_MODEM_STATUS: s_next.prdata = {24'h0, msr_val};
            ucf_pkg::ADDR_SCRATCH_PAD: s_next.prdata = {24'h0, s_reg.scratch_pad};
            ucf_pkg::ADDR_DIV_LOW: s_next.prdata = {24'h0, s_reg.div_lo};
            ucf_pkg::ADDR_DIV_HIGH: s_next.prdata = {24'h0, s_reg.div_hi};
            ucf_pkg::ADDR_DIV_FRACTION: s_next.prdata = {24'h0, s_reg.div_frac};
            ucf_pkg::ADDR_ENH_FEATURES: s_next.prdata = {24'h0, s_reg.enhanced_features};
            ucf_pkg::ADDR_FLOW_ON_FIRST: s_next.prdata = {24'h0, s_reg.flow_on_char_first};
            ucf_pkg::ADDR_FLOW_ON_SECOND: s_next.prdata = {24'h0, s_reg.flow_on_char_second};
            ucf_pkg::ADDR_FLOW_OFF_FIRST: s_next.prdata = {24'h0, s_reg.flow_off_char_first};
            ucf_pkg::ADDR_FLOW_OFF_SECOND: s_next.prdata = {24'h0, s_reg.flow_off_char_second};
            ucf_pkg::ADDR_EVENT_STATUS: s_next.prdata = {29'h0, s_reg.evt};
            ucf_pkg::ADDR_EVENT_MASK: s_next.prdata = {29'h0, s_reg.evt_mask};
            default: s_next.prdata = 32'h0000_0000;
         endcase
      end
      // Reset pin: divisor bytes and the holding byte are left as they are
      if (hw_reset) begin
         s_next.div_frac = ucf_pkg::RST_ZERO;
         s_next.irq_enable = ucf_pkg::RST_ZERO;
         s_next.queue_control = ucf_pkg::RST_ZERO;
         s_next.line_control = ucf_pkg::RST_ZERO;
         s_next.modem_control = ucf_pkg::RST_ZERO;
         s_next.enhanced_features = ucf_pkg::RST_ZERO;
         s_next.flow_on_char_first = ucf_pkg::RST_ZERO;
         s_next.flow_on_char_second = ucf_pkg::RST_ZERO;
         s_next.flow_off_char_first = ucf_pkg::RST_ZERO;
         s_next.flow_off_char_second = ucf_pkg::RST_ZERO;
         s_next.scratch_pad = ucf_pkg::RST_SCRATCH;
         s_next.thr_full = 1'b0;
         s_next.msr_delta = 4'h0;
         s_next.evt = 3'h0;
         s_next.evt_mask = 3'h0;
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         s_reg <= '0;
         s_reg.div_hi <= ucf_pkg::RST_DIV_HIGH;
         s_reg.div_lo <= ucf_pkg::RST_DIV_LOW;
         s_reg.scratch_pad <= ucf_pkg::RST_SCRATCH;
         s_reg.modem_q <= ucf_pkg::MODEM_IN_IDLE;
      end else begin
         s_reg <= s_next;
      end
   end

   // ----------------------------------------------------------------
   // Outputs
   // ----------------------------------------------------------------
   assign prdata = s_reg.prdata;
   assign pslverr = 1'b0;
   assign tx_out = tx_line;
   assign rts_n = !s_reg.modem_control[ucf_pkg::MCR_RTS];
   assign dtr_n = !s_reg.modem_control[ucf_pkg::MCR_DTR];
   // No receiver in this channel, so receive-ready never asserts
   assign receive_ready_n = 1'b1;
   assign transmit_ready_n = s_reg.thr_full;

   assign irq_pending = |(s_reg.evt & s_reg.evt_mask);
   assign irq_level = irq_pending;
   // Select low lets the pin float unless a request is pending; 68 mode is open drain
   assign irq_out = bus_mode_68 ? 1'b0 : irq_pending;
   assign irq_oe = bus_mode_68 ? irq_pending : (irq_output_select || irq_pending);

   // ----------------------------------------------------------------
   // Assertions
   // ----------------------------------------------------------------
   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);

   sequence s_frac_write_locked;
      wr_acc && paddr == ucf_pkg::ADDR_DIV_FRACTION && !enh && !hw_reset;
   endsequence

   sequence s_pin_reset;
      hw_reset ##1 !hw_reset;
   endsequence

   AST_GATE_OFF: assert property (!s_reg.enhanced_features[7] && s_reg.thr_full && !tx_busy && !hw_reset
      |=> tx_busy) else $error("gating off but character not started");
   AST_CTS_HOLD: assert property (s_reg.enhanced_features[7] && s_reg.modem_q[0] && !tx_busy
      |-> !tx_load) else $error("character started while clear-to-send high");
   AST_CTS_RESUME: assert property (s_reg.enhanced_features[7] && !s_reg.modem_q[0] && s_reg.thr_full
      && !tx_busy && !hw_reset |=> tx_busy) else $error("queued character not resumed");
   AST_FINISH_CHAR: assert property (tx_busy && !tx_done && !hw_reset && $rose(s_reg.modem_q[0])
      |-> ##1 (tx_busy || tx_done)) else $error("character cut short by clear-to-send");
   AST_FLOW_CHARS: assert property (wr_acc && paddr == ucf_pkg::ADDR_FLOW_OFF_SECOND && !hw_reset
      |=> s_reg.flow_off_char_second == $past(pwdata[7:0])) else $error("flow-off char not stored");
   AST_DIV_KEEP: assert property (s_pin_reset |-> $stable(s_reg.div_hi) && $stable(s_reg.div_lo))
      else $error("reset pin altered the divisor");
   AST_RST_CLEAR: assert property (hw_reset |=> s_reg.enhanced_features == 8'h00 && s_reg.irq_enable == 8'h00
      && s_reg.modem_control == 8'h00 && s_reg.flow_on_char_first == 8'h00 && s_reg.div_frac == 8'h00)
      else $error("register not cleared by reset");
   AST_RST_ISR: assert property (hw_reset |=> isr_val == 8'h01)
      else $error("interrupt source not idle after reset");
   AST_RST_LSR: assert property (hw_reset ##1 !tx_busy |-> lsr_val == 8'h60)
      else $error("line status not 0x60 after reset");
   AST_RST_SPR: assert property (hw_reset |=> s_reg.scratch_pad == 8'hff)
      else $error("scratch pad not 0xff after reset");
   AST_RST_MSR: assert property (hw_reset |=> msr_val[3:0] == 4'h0
      && msr_val[7:4] == ~$past(modem_now)) else $error("modem status wrong after reset");
   AST_IRQ_FLOAT: assert property (hw_reset ##1 (!bus_mode_68 && !irq_output_select)
      |-> !irq_oe) else $error("interrupt pin driven with select low");
   AST_RST_PINS: assert property (hw_reset [*2] |-> tx_out && rts_n && dtr_n
      && receive_ready_n && !transmit_ready_n) else $error("pin levels wrong in reset");
   AST_FRAC_LOCK: assert property (s_frac_write_locked |=> $stable(s_reg.div_frac))
      else $error("fraction changed while locked");
endmodule // ucf_top

// ### design/ucf_tx_shift.sv
// Transmit shifter: start bit, eight data bits LSB first, one stop bit.
// Assumes load is offered only while busy is low.
`timescale 1ns/1ps
module ucf_tx_shift (
   // Clock and resets
   input wire logic pclk,
   input wire logic presetn,
   input wire logic hw_reset,
   // Timing and character in
   input wire logic tick,
   input wire logic load,
   input wire logic [7:0] data,
   // Line and status
   output logic tx,
   output logic busy,
   output logic done
);
   typedef struct packed {
      logic [9:0] sh;
      logic [3:0] tcnt;
      logic [3:0] bcnt;
      logic busy;
      logic done;
   } ucf_sh_state_t;

   ucf_sh_state_t s_reg, s_next;

   always_comb begin
      s_next = s_reg;
      s_next.done = 1'b0;
      if (hw_reset) begin
         s_next = '0;
         s_next.sh = 10'h3ff;
      end else if (load && !s_reg.busy) begin
         s_next.sh = {1'b1, data, 1'b0};
         s_next.tcnt = 4'h0;
         s_next.bcnt = 4'h0;
         s_next.busy = 1'b1;
      end else if (s_reg.busy && tick) begin
         s_next.tcnt = s_reg.tcnt + 4'h1;
         if (s_reg.tcnt == ucf_pkg::TICKS_LAST) begin
            s_next.sh = {1'b1, s_reg.sh[9:1]};
            s_next.bcnt = s_reg.bcnt + 4'h1;
            if (s_reg.bcnt == ucf_pkg::BITS_LAST) begin
               s_next.busy = 1'b0;
               s_next.done = 1'b1;
            end
         end
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         s_reg <= '0;
         s_reg.sh <= 10'h3ff;
      end else begin
         s_reg <= s_next;
      end
   end

   assign tx = s_reg.sh[0];
   assign busy = s_reg.busy;
   assign done = s_reg.done;
endmodule // ucf_tx_shift

// ### inc/ucf_pkg.sv
// Package for one serial channel: register map, reset values, field positions
// and bit timing. Assumes a 32-bit APB with one register per aligned word.
package ucf_pkg;
   // ----------------------------------------------------------------
   // Register byte addresses
   // ----------------------------------------------------------------
   localparam logic [7:0] ADDR_HOLDING = 8'h00;
   localparam logic [7:0] ADDR_IRQ_ENABLE = 8'h04;
   localparam logic [7:0] ADDR_IRQ_SOURCE = 8'h08;
   localparam logic [7:0] ADDR_LINE_CONTROL = 8'h0c;
   localparam logic [7:0] ADDR_MODEM_CONTROL = 8'h10;
   localparam logic [7:0] ADDR_LINE_STATUS = 8'h14;
   localparam logic [7:0] ADDR_MODEM_STATUS = 8'h18;
   localparam logic [7:0] ADDR_SCRATCH_PAD = 8'h1c;
   localparam logic [7:0] ADDR_DIV_LOW = 8'h20;
   localparam logic [7:0] ADDR_DIV_HIGH = 8'h24;
   localparam logic [7:0] ADDR_DIV_FRACTION = 8'h28;
   localparam logic [7:0] ADDR_ENH_FEATURES = 8'h2c;
   localparam logic [7:0] ADDR_FLOW_ON_FIRST = 8'h30;
   localparam logic [7:0] ADDR_FLOW_ON_SECOND = 8'h34;
   localparam logic [7:0] ADDR_FLOW_OFF_FIRST = 8'h38;
   localparam logic [7:0] ADDR_FLOW_OFF_SECOND = 8'h3c;
   localparam logic [7:0] ADDR_EVENT_STATUS = 8'h40;
   localparam logic [7:0] ADDR_EVENT_MASK = 8'h44;
   // ----------------------------------------------------------------
   // Reset values
   // ----------------------------------------------------------------
   localparam logic [7:0] RST_ZERO = 8'h00;
   localparam logic [7:0] RST_DIV_HIGH = 8'h00;
   localparam logic [7:0] RST_DIV_LOW = 8'h01;
   localparam logic [7:0] RST_SCRATCH = 8'hff;
   localparam logic [7:0] ISR_NONE = 8'h01;
   localparam logic [7:0] ISR_THR_EMPTY = 8'h02;
   localparam logic [7:0] ISR_MODEM = 8'h00;
   localparam logic [7:0] RX_HOLDING_IDLE = 8'h00;
   localparam logic [3:0] MODEM_IN_IDLE = 4'hf;
   // ----------------------------------------------------------------
   // Field positions
   // ----------------------------------------------------------------
   localparam int EFR_ENH_ENABLE = 4;
   localparam int EFR_AUTO_CTS = 7;
   localparam int IER_THR_EMPTY = 1;
   localparam int IER_MODEM = 3;
   localparam int FCR_TX_CLEAR = 2;
   localparam int MCR_DTR = 0;
   localparam int MCR_RTS = 1;
   localparam int EVT_THR_EMPTY = 0;
   localparam int EVT_CTS_CHANGE = 1;
   localparam int EVT_CHAR_DONE = 2;
   // ----------------------------------------------------------------
   // Bit timing: 16 baud ticks per bit, start + 8 data + stop
   // ----------------------------------------------------------------
   localparam logic [3:0] TICKS_LAST = 4'hf;
   localparam logic [3:0] BITS_LAST = 4'h9;
endpackage

// ### tb/tb_ucf_top.sv
// Bench for one serial channel: APB register tests, clear-to-send gating, resets.
// Assumes zero-wait APB and the peer model on the serial side.
`timescale 1ns/1ps
module tb_ucf_top;
   logic pclk = 0, presetn = 0, hw_reset = 0, psel = 0, penable = 0, pwrite = 0;
   logic [7:0] paddr = 8'h00, q, rx_byte;
   logic [31:0] pwdata = 32'h0, prdata;
   logic pready, cts_n, tx_out, rts_n, dtr_n, receive_ready_n, transmit_ready_n;
   logic sel = 0, m68 = 0, stop = 1, irq_out, irq_oe, irq_level;
   int rx_count, bad_count = 0, cmp_count = 0;
   localparam logic [7:0] RA [14] = '{8'h04, 8'h08, 8'h0c, 8'h10, 8'h14, 8'h18, 8'h1c,
      8'h24, 8'h28, 8'h2c, 8'h30, 8'h34, 8'h38, 8'h3c};
   localparam logic [7:0] RE [14] = '{8'h00, 8'h01, 8'h00, 8'h00, 8'h60, 8'h20, 8'hff,
      8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00};
   ucf_top ucf_top_i (.pclk(pclk), .presetn(presetn), .hw_reset(hw_reset), .psel(psel),
      .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
      .pready(pready), .pslverr(), .cts_n(cts_n), .dsr_n(1'b0), .ri_n(1'b1), .cd_n(1'b1),
      .tx_out(tx_out), .rts_n(rts_n), .dtr_n(dtr_n), .receive_ready_n(receive_ready_n),
      .transmit_ready_n(transmit_ready_n), .irq_output_select(sel), .bus_mode_68(m68),
      .irq_out(irq_out), .irq_oe(irq_oe), .irq_level(irq_level));
   ucf_peer ucf_peer_i (.pclk(pclk), .tx_out(tx_out), .stop(stop), .cts_n(cts_n),
      .rx_byte(rx_byte), .rx_count(rx_count));
   always #20 pclk = ~pclk;
   // ----------------------------------------------------------------
   // Bus and compare tasks
   // ----------------------------------------------------------------
   task automatic apb(input logic w, input logic [7:0] a, input logic [7:0] d);
      @(posedge pclk);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= {24'h0, d};
      @(posedge pclk);
      penable <= 1'b1;
      do @(posedge pclk); while (pready !== 1'b1);
      q = prdata[7:0];
      psel <= 1'b0;
      penable <= 1'b0;
   endtask
   task automatic cmp(input logic [7:0] g, input logic [7:0] e);
      cmp_count++;
      if (g !== e) begin
         $display("[FAIL] %0t got %h exp %h", $time, g, e);
         bad_count++;
      end
   endtask
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      apb(1'b1, a, d);
   endtask
   task automatic chk(input logic [7:0] a, input logic [7:0] e);
      apb(1'b0, a, 8'h00);
      cmp(q, e);
   endtask
   task automatic waitc(input int n);
      int t = 0;
      while (rx_count < n && t < 3000) begin
         @(posedge pclk);
         t++;
      end
      if (rx_count < n) begin
         $display("[FAIL] %0t no character from peer", $time);
         bad_count++;
      end
   endtask
   task automatic rst_tbl(input logic [7:0] dl);
      for (int i = 0; i < 14; i++) chk(RA[i], RE[i]);
      chk(8'h20, dl);
   endtask
   task automatic pins;
      @(negedge pclk);
      cmp({3'b0, tx_out, rts_n, dtr_n, receive_ready_n, transmit_ready_n}, 8'h1e);
      cmp({6'b0, irq_oe, irq_out}, sel ? 8'h02 : 8'h00);
   endtask
   task complete_run;
      if (bad_count == 0 && cmp_count > 0) $display("No errors found");
      else $display("Errors were found");
      $finish;
   endtask
   initial begin
      #200000;
      $display("[FAIL] %0t watchdog expired", $time);
      bad_count++;
      complete_run;
   end
   // ----------------------------------------------------------------
   // Test sequence
   // ----------------------------------------------------------------
   initial begin
      int t;
      pins;
      @(posedge pclk);
      presetn <= 1'b1;
      rst_tbl(8'h01);
      wr(8'h2c, 8'h90);
      wr(8'h44, 8'h04);
      wr(8'h00, 8'h5a);
      repeat (100) @(posedge pclk);
      cmp(8'(rx_count), 8'h00);
      stop <= 1'b0;
      waitc(1);
      cmp(rx_byte, 8'h5a);
      repeat (16) @(posedge pclk);
      cmp({7'b0, irq_level}, 8'h01);
      chk(8'h40, 8'h07);
      @(negedge pclk);
      cmp({7'b0, irq_level}, 8'h00);
      wr(8'h00, 8'ha5);
      t = 0;
      while (tx_out !== 1'b0 && t < 500) begin
         @(posedge pclk);
         t++;
      end
      if (tx_out !== 1'b0) begin
         $display("[FAIL] %0t start bit not seen", $time);
         bad_count++;
      end
      stop <= 1'b1;
      waitc(2);
      cmp(rx_byte, 8'ha5);
      wr(8'h00, 8'h3c);
      repeat (200) @(posedge pclk);
      cmp(8'(rx_count), 8'h02);
      cmp({7'b0, transmit_ready_n}, 8'h01);
      wr(8'h2c, 8'h10);
      waitc(3);
      cmp(rx_byte, 8'h3c);
      wr(8'h28, 8'h05);
      chk(8'h28, 8'h05);
      wr(8'h2c, 8'h00);
      wr(8'h28, 8'h0a);
      chk(8'h28, 8'h05);
      for (int i = 0; i < 4; i++) wr(8'h30 + 8'(4 * i), 8'hc0 + 8'(i));
      for (int i = 0; i < 4; i++) chk(8'h30 + 8'(4 * i), 8'hc0 + 8'(i));
      wr(8'h10, 8'h03);
      @(negedge pclk);
      cmp({6'b0, rts_n, dtr_n}, 8'h00);
      wr(8'h20, 8'h02);
      wr(8'h1c, 8'h33);
      sel <= 1'b1;
      hw_reset <= 1'b1;
      repeat (2) @(posedge pclk);
      pins;
      @(posedge pclk);
      hw_reset <= 1'b0;
      rst_tbl(8'h02);
      sel <= 1'b0;
      hw_reset <= 1'b1;
      repeat (2) @(posedge pclk);
      pins;
      @(posedge pclk);
      hw_reset <= 1'b0;
      m68 <= 1'b1;
      @(negedge pclk);
      cmp({6'b0, irq_oe, irq_out}, 8'h00);
      complete_run;
   end
endmodule // tb_ucf_top

// ### tb/ucf_peer.sv
// Serial peer: takes 8N1 frames off tx_out and drives clear-to-send.
// Assumes a divisor of one, so one bit lasts BIT_CLKS clocks.
`timescale 1ns/1ps
module ucf_peer #(parameter int BIT_CLKS = 16) (
   // Clock and line
   input wire logic pclk,
   input wire logic tx_out,
   // Flow control request from the bench
   input wire logic stop,
   output logic cts_n,
   // Received characters
   output logic [7:0] rx_byte,
   output int rx_count
);
   logic [7:0] b;
   always @(posedge pclk) cts_n <= stop;
   initial begin
      rx_count = 0;
      forever begin
         @(negedge tx_out);
         repeat (BIT_CLKS / 2) @(posedge pclk);
         for (int i = 0; i < 8; i++) begin
            repeat (BIT_CLKS) @(posedge pclk);
            b[i] = tx_out;
         end
         repeat (BIT_CLKS) @(posedge pclk);
         // A missing stop bit poisons the byte so that any compare fails
         rx_byte = tx_out ? b : 8'hxx;
         rx_count++;
      end
   end
endmodule // ucf_peer
